//--- pkg/pils_params.svh
`ifndef PILS_PARAMS_SVH
`define PILS_PARAMS_SVH

// major opcodes
`define OPC_IMM_LOAD 7'h0B
`define OPC_CUSTOM 7'h2B

// funct3 codes
`define F3_B 3'h0
`define F3_H 3'h1
`define F3_W 3'h2
`define F3_RR 3'h3
`define F3_BU 3'h4
`define F3_HU 3'h5

// funct7: post-increment register-register loads
`define F7_PL_B 7'h00
`define F7_PL_BU 7'h08
`define F7_PL_H 7'h01
`define F7_PL_HU 7'h09
`define F7_PL_W 7'h02
// funct7: indexed loads
`define F7_IL_B 7'h04
`define F7_IL_BU 7'h0C
`define F7_IL_H 7'h05
`define F7_IL_HU 7'h0D
`define F7_IL_W 7'h06
// funct7: post-increment register-register stores
`define F7_PS_B 7'h10
`define F7_PS_H 7'h11
`define F7_PS_W 7'h12
// funct7: indexed stores
`define F7_IS_B 7'h14
`define F7_IS_H 7'h15
`define F7_IS_W 7'h16

// reset values
`define RST_READY 1'b1
`define RST_WORD 32'h0000_0000

`endif

//--- pkg/pils_pkg.sv
package pils_pkg;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } size_t;

  typedef enum logic [1:0] {
    AM_POST_IMM = 2'h0,
    AM_POST_REG = 2'h1,
    AM_INDEX = 2'h2
  } addr_mode_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_READ = 6'b000010,
    ST_MEM = 6'b000100,
    ST_WAIT = 6'b001000,
    ST_WBASE = 6'b010000,
    ST_WLOAD = 6'b100000
  } state_t;

  typedef struct packed {
    logic ok;
    logic is_load;
    size_t size;
    logic uns;
    addr_mode_t mode;
    logic [4:0] rd;
    logic [4:0] rs1;
    logic [4:0] rs2;
    logic [4:0] rs3;
    logic [31:0] imm;
  } dec_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmem_req_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [31:0] data;
  } rf_wr_t;

endpackage

//--- rtl/post_increment_load_store_decode.sv
// How it works
// - post-increment: access at old base, then write base plus offset back
// - base always from rs1; offset from immediate or a second register
// - custom encodings decode only when the enable parameter equals 1
// - same destination and base on post-increment load: loaded data wins
// - immediate post-increment loads: b/bu/h/hu/w at rs1, rs1 += sext imm
// - register post-increment loads: b/bu/h/hu/w at rs1, rs1 += rs2
// - indexed loads read at rs1 plus rs2, rs1 unchanged
// - opcode 0001011, imm in 31:20, funct3 selects size and sign
// - opcode 0101011 funct3 011, rs2 offset for loads, rs3 for stores, funct7 selects variant
// - immediate post-increment stores: split immediate, funct3 000/001/010
// - register post-increment stores: rs3 in 11:7, funct7 0010000..0010010
// - indexed stores write rs2 at rs1 plus rs3, rs1 unchanged
`timescale 1ns/10ps
`default_nettype none
`include "pils_params.svh"

module post_increment_load_store_decode #(
  parameter bit CUSTOM_EXTENSION_ENABLE_PARAM = 1'b1
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  output logic INSTR_READY,
  output logic [4:0] RF_RADDR_A,
  output logic [4:0] RF_RADDR_B,
  output logic [4:0] RF_RADDR_C,
  input wire logic [31:0] RF_RDATA_A,
  input wire logic [31:0] RF_RDATA_B,
  input wire logic [31:0] RF_RDATA_C,
  output pils_pkg::dmem_req_t DMEM_REQ,
  input wire logic DMEM_GNT,
  input wire logic DMEM_RVALID,
  input wire logic [31:0] DMEM_RDATA,
  output pils_pkg::rf_wr_t RF_WR,
  output logic DONE,
  output logic ILLEGAL
);
  import pils_pkg::*;

  state_t state_r, state_nxt;
  dec_t dec_r, dec_nxt, dec_in;
  dmem_req_t mem_r, mem_nxt;
  rf_wr_t rf_r, rf_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic illegal_r, illegal_nxt;
  logic [31:0] off_r, off_nxt;
  logic [31:0] base_r, base_nxt;
  logic [31:0] load_r, load_nxt;
  logic [31:0] offv;
  logic [31:0] ea;
  logic [31:0] ld;
  logic wb_base;
  logic wb_load;

  function automatic dec_t rr(input dec_t d, input logic ld_i, input addr_mode_t m,
                              input size_t s, input logic u);
    dec_t r;
    r = d;
    r.ok = 1'b1;
    r.is_load = ld_i;
    r.mode = m;
    r.size = s;
    r.uns = u;
    return r;
  endfunction

  function automatic dec_t decode(input logic [31:0] i);
    dec_t d;
    d = '0;
    d.rd = i[11:7];
    d.rs1 = i[19:15];
    d.rs2 = i[24:20];
    d.rs3 = i[11:7];
    if (i[6:0] == `OPC_IMM_LOAD) begin
      d.imm = {{20{i[31]}}, i[31:20]};
      unique case (i[14:12])
        `F3_B: d = rr(d, 1'b1, AM_POST_IMM, SZ_BYTE, 1'b0);
        `F3_BU: d = rr(d, 1'b1, AM_POST_IMM, SZ_BYTE, 1'b1);
        `F3_H: d = rr(d, 1'b1, AM_POST_IMM, SZ_HALF, 1'b0);
        `F3_HU: d = rr(d, 1'b1, AM_POST_IMM, SZ_HALF, 1'b1);
        `F3_W: d = rr(d, 1'b1, AM_POST_IMM, SZ_WORD, 1'b0);
        default: d.ok = 1'b0;
      endcase
    end else if (i[6:0] == `OPC_CUSTOM) begin
      d.imm = {{20{i[31]}}, i[31:25], i[11:7]};
      unique case (i[14:12])
        `F3_B: d = rr(d, 1'b0, AM_POST_IMM, SZ_BYTE, 1'b0);
        `F3_H: d = rr(d, 1'b0, AM_POST_IMM, SZ_HALF, 1'b0);
        `F3_W: d = rr(d, 1'b0, AM_POST_IMM, SZ_WORD, 1'b0);
        `F3_RR: begin
          unique case (i[31:25])
            `F7_PL_B: d = rr(d, 1'b1, AM_POST_REG, SZ_BYTE, 1'b0);
            `F7_PL_BU: d = rr(d, 1'b1, AM_POST_REG, SZ_BYTE, 1'b1);
            `F7_PL_H: d = rr(d, 1'b1, AM_POST_REG, SZ_HALF, 1'b0);
            `F7_PL_HU: d = rr(d, 1'b1, AM_POST_REG, SZ_HALF, 1'b1);
            `F7_PL_W: d = rr(d, 1'b1, AM_POST_REG, SZ_WORD, 1'b0);
            `F7_IL_B: d = rr(d, 1'b1, AM_INDEX, SZ_BYTE, 1'b0);
            `F7_IL_BU: d = rr(d, 1'b1, AM_INDEX, SZ_BYTE, 1'b1);
            `F7_IL_H: d = rr(d, 1'b1, AM_INDEX, SZ_HALF, 1'b0);
            `F7_IL_HU: d = rr(d, 1'b1, AM_INDEX, SZ_HALF, 1'b1);
            `F7_IL_W: d = rr(d, 1'b1, AM_INDEX, SZ_WORD, 1'b0);
            `F7_PS_B: d = rr(d, 1'b0, AM_POST_REG, SZ_BYTE, 1'b0);
            `F7_PS_H: d = rr(d, 1'b0, AM_POST_REG, SZ_HALF, 1'b0);
            `F7_PS_W: d = rr(d, 1'b0, AM_POST_REG, SZ_WORD, 1'b0);
            `F7_IS_B: d = rr(d, 1'b0, AM_INDEX, SZ_BYTE, 1'b0);
            `F7_IS_H: d = rr(d, 1'b0, AM_INDEX, SZ_HALF, 1'b0);
            `F7_IS_W: d = rr(d, 1'b0, AM_INDEX, SZ_WORD, 1'b0);
            default: d.ok = 1'b0;
          endcase
        end
        default: d.ok = 1'b0;
      endcase
    end
    d.ok = d.ok & (CUSTOM_EXTENSION_ENABLE_PARAM == 1'b1);
    return d;
  endfunction

  // misaligned half or word accesses are forced onto their natural lane
  function automatic logic [1:0] lane(input size_t s, input logic [1:0] a);
    logic [1:0] l;
    l = 2'h0;
    if (s == SZ_BYTE) begin
      l = a;
    end else if (s == SZ_HALF) begin
      l = {a[1], 1'b0};
    end
    return l;
  endfunction

  function automatic logic [3:0] strobes(input size_t s, input logic [1:0] a);
    logic [3:0] b;
    b = 4'hF;
    if (s == SZ_BYTE) begin
      b = 4'h1 << lane(s, a);
    end else if (s == SZ_HALF) begin
      b = 4'h3 << lane(s, a);
    end
    return b;
  endfunction

  function automatic logic [31:0] pack_store(input size_t s, input logic [31:0] v);
    logic [31:0] w;
    // replicated so whichever lane the strobes pick carries the data
    w = (s == SZ_BYTE) ? {4{v[7:0]}} : ((s == SZ_HALF) ? {2{v[15:0]}} : v);
    return w;
  endfunction

  function automatic logic [31:0] extract(input logic [31:0] w, input logic [1:0] a,
                                          input size_t s, input logic u);
    logic [31:0] sh;
    logic [31:0] r;
    sh = w >> {lane(s, a), 3'h0};
    r = sh;
    if (s == SZ_BYTE) begin
      r = {{24{sh[7] & ~u}}, sh[7:0]};
    end else if (s == SZ_HALF) begin
      r = {{16{sh[15] & ~u}}, sh[15:0]};
    end
    return r;
  endfunction

  always_comb begin
    state_nxt = state_r;
    dec_nxt = dec_r;
    mem_nxt = mem_r;
    ready_nxt = ready_r;
    off_nxt = off_r;
    base_nxt = base_r;
    load_nxt = load_r;
    rf_nxt = '0;
    done_nxt = 1'b0;
    illegal_nxt = 1'b0;
    dec_in = decode(INSTR);
    // loads take the register offset from rs2, stores from rs3
    offv = (dec_r.mode == AM_POST_IMM) ? dec_r.imm :
           (dec_r.is_load ? RF_RDATA_B : RF_RDATA_C);
    ea = (dec_r.mode == AM_INDEX) ? RF_RDATA_A + offv : RF_RDATA_A;
    ld = extract(DMEM_RDATA, mem_r.addr[1:0], dec_r.size, dec_r.uns);
    // base write skipped when the load lands in the same register
    wb_base = (dec_r.mode != AM_INDEX) && (dec_r.rs1 != 5'h00) &&
              !(dec_r.is_load && (dec_r.rd == dec_r.rs1));
    wb_load = dec_r.is_load && (dec_r.rd != 5'h00);
    unique case (state_r)
      ST_IDLE: begin
        if (INSTR_VALID && ready_r) begin
          if (dec_in.ok) begin
            dec_nxt = dec_in;
            ready_nxt = 1'b0;
            state_nxt = ST_READ;
          end else begin
            illegal_nxt = 1'b1;
          end
        end
      end
      ST_READ: begin
        off_nxt = offv;
        base_nxt = RF_RDATA_A + offv;
        mem_nxt.req = 1'b1;
        mem_nxt.we = !dec_r.is_load;
        mem_nxt.addr = ea;
        mem_nxt.be = strobes(dec_r.size, ea[1:0]);
        mem_nxt.wdata = pack_store(dec_r.size, RF_RDATA_B);
        state_nxt = ST_MEM;
      end
      ST_MEM: begin
        if (DMEM_GNT) begin
          mem_nxt.req = 1'b0;
          if (dec_r.is_load) begin
            state_nxt = ST_WAIT;
          end else if (wb_base) begin
            rf_nxt = '{we: 1'b1, addr: dec_r.rs1, data: base_r};
            state_nxt = ST_WBASE;
          end else begin
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        if (DMEM_RVALID) begin
          load_nxt = ld;
          if (wb_base) begin
            rf_nxt = '{we: 1'b1, addr: dec_r.rs1, data: base_r};
            state_nxt = ST_WBASE;
          end else if (wb_load) begin
            rf_nxt = '{we: 1'b1, addr: dec_r.rd, data: ld};
            state_nxt = ST_WLOAD;
          end else begin
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_WBASE: begin
        if (wb_load) begin
          rf_nxt = '{we: 1'b1, addr: dec_r.rd, data: load_r};
          state_nxt = ST_WLOAD;
        end else begin
          done_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_WLOAD: begin
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_IDLE;
      dec_r <= '0;
      mem_r <= '0;
      rf_r <= '0;
      ready_r <= `RST_READY;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      off_r <= `RST_WORD;
      base_r <= `RST_WORD;
      load_r <= `RST_WORD;
    end else begin
      state_r <= state_nxt;
      dec_r <= dec_nxt;
      mem_r <= mem_nxt;
      rf_r <= rf_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      illegal_r <= illegal_nxt;
      off_r <= off_nxt;
      base_r <= base_nxt;
      load_r <= load_nxt;
    end
  end

  assign INSTR_READY = ready_r;
  assign RF_RADDR_A = dec_r.rs1;
  assign RF_RADDR_B = dec_r.rs2;
  assign RF_RADDR_C = dec_r.rs3;
  assign DMEM_REQ = mem_r;
  assign RF_WR = rf_r;
  assign DONE = done_r;
  assign ILLEGAL = illegal_r;

  AST_DISABLED_NO_ACCESS: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (CUSTOM_EXTENSION_ENABLE_PARAM == 1'b0) |-> !mem_r.req && !rf_r.we)
    else $error("access made while extension disabled");
  AST_REJECT_ILLEGAL: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (state_r == ST_IDLE && INSTR_VALID && ready_r && !dec_in.ok)
    |=> ILLEGAL && $stable(state_r) ##1 (ILLEGAL == $past(INSTR_VALID && !dec_in.ok)))
    else $error("illegal encoding not flagged for one cycle");
  AST_POST_ADDR_IS_BASE: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (state_r == ST_READ && dec_r.mode != AM_INDEX)
    |=> mem_r.req && mem_r.addr == $past(RF_RDATA_A))
    else $error("post-increment access not at base");
  AST_INDEX_ADDR: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (state_r == ST_READ && dec_r.mode == AM_INDEX)
    |=> mem_r.addr == $past(RF_RDATA_A) + off_r)
    else $error("indexed access address wrong");
  AST_INDEX_KEEPS_BASE: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (dec_r.mode == AM_INDEX) |-> state_r != ST_WBASE)
    else $error("indexed access wrote the base register");
  AST_BASE_WRITEBACK: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (state_r == ST_WBASE)
    |-> rf_r.we && rf_r.addr == dec_r.rs1 && rf_r.data == mem_r.addr + off_r)
    else $error("base write-back value wrong");
  AST_LOAD_WINS: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (state_r == ST_WAIT && DMEM_RVALID && dec_r.rd == dec_r.rs1 && dec_r.rd != 5'h00)
    |=> state_r == ST_WLOAD && rf_r.addr == dec_r.rd ##1 done_r)
    else $error("same-register load did not keep loaded data");
  AST_REQ_HELD: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (mem_r.req && !DMEM_GNT) |=> mem_r.req && $stable(mem_r.addr) && $stable(mem_r.be))
    else $error("memory request dropped before grant");
  AST_STORE_STROBES: assert property (
    @(posedge REF_CLK) disable iff (!NRST)
    (mem_r.req && mem_r.we && dec_r.size == SZ_HALF) |-> $countones(mem_r.be) == 2)
    else $error("halfword store strobes wrong");

endmodule

`default_nettype wire

//--- verification/pils_mem_rf_model.sv
`timescale 1ns/10ps
`default_nettype none

module pils_mem_rf_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] raddr_a,
  input wire logic [4:0] raddr_b,
  input wire logic [4:0] raddr_c,
  output logic [31:0] rdata_a,
  output logic [31:0] rdata_b,
  output logic [31:0] rdata_c,
  input wire pils_pkg::dmem_req_t req,
  output logic gnt,
  output logic rvalid,
  output logic [31:0] rdata,
  input wire pils_pkg::rf_wr_t wr,
  input wire logic [1:0] gnt_dly
);
  import pils_pkg::*;
  logic [31:0] rf [32];
  logic [31:0] mem [64];
  logic [1:0] cnt;
  logic pend;
  logic [5:0] pidx;

  assign rdata_a = rf[raddr_a];
  assign rdata_b = rf[raddr_b];
  assign rdata_c = rf[raddr_c];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gnt <= 1'b0;
      rvalid <= 1'b0;
      cnt <= 2'h0;
      pend <= 1'b0;
      rdata <= 32'hA5A5_A5A5;
    end else begin
      gnt <= 1'b0;
      rvalid <= 1'b0;
      // data bus toggles when not valid so stale data never looks right
      rdata <= ~rdata;
      if (req.req && !gnt) begin
        if (cnt == gnt_dly) begin
          gnt <= 1'b1;
          cnt <= 2'h0;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
      if (req.req && gnt) begin
        if (req.we) begin
          for (int i = 0; i < 4; i++) begin
            if (req.be[i]) begin
              mem[req.addr[7:2]][8*i +: 8] <= req.wdata[8*i +: 8];
            end
          end
        end else begin
          pend <= 1'b1;
          pidx <= req.addr[7:2];
        end
      end
      if (pend) begin
        pend <= 1'b0;
        rvalid <= 1'b1;
        rdata <= mem[pidx];
      end
      if (wr.we && wr.addr != 5'h00) begin
        rf[wr.addr] <= wr.data;
      end
    end
  end
endmodule

`default_nettype wire

//--- verification/post_increment_load_store_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none

module post_increment_load_store_decode_tb;
  import pils_pkg::*;
  logic clk, rst_n, valid, valid_off, ready, ready_off, done, ill, ill_off, gnt, rvalid;
  logic [31:0] instr, rda, rdb, rdc, mrdata;
  logic [4:0] ra, rb, rc;
  logic [1:0] gdly;
  dmem_req_t req;
  rf_wr_t wr;
  int bad_count, n_tests;

  post_increment_load_store_decode #(.CUSTOM_EXTENSION_ENABLE_PARAM(1'b1)) i_dut (
    .REF_CLK(clk), .NRST(rst_n), .INSTR_VALID(valid), .INSTR(instr), .INSTR_READY(ready),
    .RF_RADDR_A(ra), .RF_RADDR_B(rb), .RF_RADDR_C(rc),
    .RF_RDATA_A(rda), .RF_RDATA_B(rdb), .RF_RDATA_C(rdc), .DMEM_REQ(req),
    .DMEM_GNT(gnt), .DMEM_RVALID(rvalid), .DMEM_RDATA(mrdata), .RF_WR(wr),
    .DONE(done), .ILLEGAL(ill));

  // extension disabled: shares all inputs but INSTR_VALID, only its handshake is watched
  post_increment_load_store_decode #(.CUSTOM_EXTENSION_ENABLE_PARAM(1'b0)) i_dut_off (
    .REF_CLK(clk), .NRST(rst_n), .INSTR_VALID(valid_off), .INSTR(instr),
    .INSTR_READY(ready_off), .RF_RADDR_A(), .RF_RADDR_B(), .RF_RADDR_C(),
    .RF_RDATA_A(rda), .RF_RDATA_B(rdb), .RF_RDATA_C(rdc), .DMEM_REQ(),
    .DMEM_GNT(gnt), .DMEM_RVALID(rvalid), .DMEM_RDATA(mrdata), .RF_WR(),
    .DONE(), .ILLEGAL(ill_off));

  pils_mem_rf_model i_p (
    .clk(clk), .rst_n(rst_n), .raddr_a(ra), .raddr_b(rb), .raddr_c(rc),
    .rdata_a(rda), .rdata_b(rdb), .rdata_c(rdc), .req(req), .gnt(gnt),
    .rvalid(rvalid), .rdata(mrdata), .wr(wr), .gnt_dly(gdly));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(logic [31:0] ins, output logic il);
    int k;
    logic rdy0;
    il = 1'b0;
    @(posedge clk);
    #1 valid = 1'b1;
    instr = ins;
    @(posedge clk);
    #1 valid = 1'b0;
    rdy0 = ready;
    for (k = 0; k < 40; k++) begin
      if (done === 1'b1) break;
      if (ill === 1'b1) begin
        il = 1'b1;
        break;
      end
      @(posedge clk);
      #1;
    end
    chk("completion", 32'h0, k == 40);
    chk("ready after offer", {31'h0, il}, {31'h0, rdy0});
    chk("ready at end", 32'h1, {31'h0, ready});
  endtask

  function automatic logic [31:0] ext(logic [31:0] w, logic [1:0] a, int sz, logic u);
    logic [31:0] s;
    s = w >> (sz == 2 ? 0 : (sz == 1 ? 16 * a[1] : 8 * a));
    if (sz == 0) return u ? {24'h0, s[7:0]} : {{24{s[7]}}, s[7:0]};
    if (sz == 1) return u ? {16'h0, s[15:0]} : {{16{s[15]}}, s[15:0]};
    return s;
  endfunction

  // base x6 = 0x43, offset x7 = 4; eb is the expected final x6
  task automatic ld(logic [31:0] ins, int sz, logic u, logic [31:0] ea, logic [31:0] eb);
    logic il;
    i_p.rf[5] = 32'h0;
    i_p.rf[6] = 32'h43;
    i_p.rf[7] = 32'h4;
    i_p.mem[ea[7:2]] = 32'h80F1_7F92;
    run(ins, il);
    chk("load accepted", 32'h0, il);
    chk("load data", ext(32'h80F1_7F92, ea[1:0], sz, u), i_p.rf[ins[11:7]]);
    chk("base reg", eb, i_p.rf[6]);
  endtask

  task automatic st(logic [31:0] ins, int sz, logic [31:0] ea, logic [31:0] eb);
    logic il;
    logic [31:0] w;
    i_p.rf[6] = 32'h43;
    i_p.rf[7] = 32'hA1B2_C3D4;
    i_p.rf[8] = 32'h4;
    i_p.mem[ea[7:2]] = 32'h1122_3344;
    w = 32'h1122_3344;
    if (sz == 2) w = 32'hA1B2_C3D4;
    else if (sz == 1) w[16*ea[1] +: 16] = 16'hC3D4;
    else w[8*ea[1:0] +: 8] = 8'hD4;
    run(ins, il);
    chk("store accepted", 32'h0, il);
    chk("store word", w, i_p.mem[ea[7:2]]);
    chk("base reg", eb, i_p.rf[6]);
  endtask

  task automatic t_loads();
    logic [2:0] f3 [5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2};
    logic [6:0] fp [5] = '{7'h00, 7'h08, 7'h01, 7'h09, 7'h02};
    logic [6:0] fi [5] = '{7'h04, 7'h0C, 7'h05, 7'h0D, 7'h06};
    int sz [5] = '{0, 0, 1, 1, 2};
    gdly = 2'h0;
    for (int i = 0; i < 5; i++) begin
      ld({12'hFFC, 5'h06, f3[i], 5'h05, 7'h0B}, sz[i], i[0], 32'h43, 32'h3F);
      ld({fp[i], 5'h07, 5'h06, 3'h3, 5'h05, 7'h2B}, sz[i], i[0], 32'h43, 32'h47);
      ld({fi[i], 5'h07, 5'h06, 3'h3, 5'h05, 7'h2B}, sz[i], i[0], 32'h47, 32'h43);
    end
    ld({12'h004, 5'h06, 3'h2, 5'h06, 7'h0B}, 2, 1'b0, 32'h43, 32'h80F1_7F92);
    ld({7'h01, 5'h07, 5'h06, 3'h3, 5'h06, 7'h2B}, 1, 1'b0, 32'h43, 32'hFFFF_80F1);
    $display("loads finished");
  endtask

  task automatic t_stores();
    gdly = 2'h3;
    for (int i = 0; i < 3; i++) begin
      st({7'h7F, 5'h07, 5'h06, i[2:0], 5'h1C, 7'h2B}, i, 32'h43, 32'h3F);
      st({7'h10 + i[6:0], 5'h07, 5'h06, 3'h3, 5'h08, 7'h2B}, i, 32'h43, 32'h47);
      st({7'h14 + i[6:0], 5'h07, 5'h06, 3'h3, 5'h08, 7'h2B}, i, 32'h47, 32'h43);
    end
    $display("stores finished");
  endtask

  task automatic t_illegal();
    logic il;
    int k;
    logic seen;
    i_p.rf[6] = 32'h43;
    run({12'h000, 5'h06, 3'h4, 4'h1, 1'b0, 7'h2B}, il);
    chk("loop encoding refused", 32'h1, il);
    run({7'h03, 5'h07, 5'h06, 3'h3, 5'h05, 7'h2B}, il);
    chk("unknown funct7 refused", 32'h1, il);
    chk("base untouched", 32'h43, i_p.rf[6]);
    seen = 1'b0;
    @(posedge clk);
    #1 valid_off = 1'b1;
    instr = {12'h004, 5'h06, 3'h2, 5'h05, 7'h0B};
    @(posedge clk);
    #1 valid_off = 1'b0;
    for (k = 0; k < 3; k++) begin
      seen |= (ill_off === 1'b1);
      @(posedge clk);
      #1;
    end
    chk("disabled refuses", 32'h1, seen);
    chk("disabled ready", 32'h1, ready_off);
    $display("illegal finished");
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    valid_off = 1'b0;
    instr = 32'h0;
    gdly = 2'h0;
    i_p.rf[0] = 32'h0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    t_loads();
    t_stores();
    t_illegal();
    finish_test();
  end

  // roughly 28 operations of about a dozen cycles each
  initial begin
    #(20 * 5000);
    bad_count++;
    finish_test();
  end
endmodule

`default_nettype wire
